// File: autoneg_pkg.sv
package autoneg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;           // 250 MHz core clock
  localparam int LT_UNIT_PS    = 32768000;       // 32.768 us per timer step
  localparam int LT_UNIT_CYC   = LT_UNIT_PS / CLK_PERIOD_PS;
  localparam int LT_PERIODS    = 3;              // Timer periods per sequence
  localparam logic [1:0] STRAP_DLY = 2'h3;       // Edges until the strap is settled

  // ----------------------------------------------------------------
  // Register map (5-bit management addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ADV  = 5'h04;
  localparam logic [4:0] REG_IRQ  = 5'h10;
  localparam logic [4:0] REG_STD  = 5'h11;

  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_ANEN_BIT    = 12;
  localparam int STAT_ABIL_BIT    = 3;
  localparam int STAT_DONE_BIT    = 5;
  localparam int IRQ_EN_BIT       = 0;
  localparam int IRQ_STAT_BIT     = 1;

  localparam logic [15:0] CTRL_RST  = 16'h1000;
  localparam logic [15:0] ADV_RST   = 16'h0020;
  localparam logic [15:0] ADV_SGMII = 16'h0001;

  // ----------------------------------------------------------------
  // Management frame
  // ----------------------------------------------------------------
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam logic [4:0] HDR_LEN = 5'h0D;
  localparam logic [4:0] RD_LEN  = 5'h11;
  localparam logic [4:0] WR_LEN  = 5'h12;
  localparam logic [1:0] OP_RD   = 2'h2;
  localparam logic [1:0] OP_WR   = 2'h1;

  typedef enum logic {STD_BASEX = 1'b0, STD_SGMII = 1'b1} std_type;
  typedef enum logic [2:0] {N_IDLE = 3'b001, N_RUN = 3'b010, N_DONE = 3'b100} neg_state_type;
  typedef enum logic [3:0] {
    M_PRE = 4'b0001, M_HDR = 4'b0010, M_RD = 4'b0100, M_WR = 4'b1000
  } mdio_state_type;

  typedef struct packed {
    logic [8:0] basex;
    logic [8:0] sgmii;
  } link_timer_type;

endpackage

// File: autoneg_standard_switch_ctrl.sv
// Summary of operation
// - Completion needs at least three full link-timer periods.
// - Register 16 holds interrupt enable and completion status.
// - Interrupt output stays low while the interrupt is disabled.
// - When enabled, interrupt output rises after a negotiation completes.
// - Interrupt stays high until zero is written to status bit 1 or to enable bit 0.
// - Strap low gives 1000BASE-X after reset.
// - Strap high gives SGMII after reset.
// - A new strap level takes effect only through a later reset.
// - Register 17 changes the standard at any time.
// - Registers 0 to 16 follow the new standard right after the write.
// - A running sequence keeps its starting standard until it ends.
// - Changing the standard does not start a sequence.
// - Writing control bit 9 starts a new sequence.
// - 1000BASE-X timer setting is sampled at each sequence start.
// - SGMII timer setting is sampled at each sequence start.
// - Dual builds take two per-standard timer settings.
// - Timer period is setting times 32.768 us.
// - Sequence starts on reset, sync loss, partner start or restart.
module autoneg_standard_switch_ctrl
  import autoneg_pkg::*;
#(
  parameter int LT_UNIT_CYCLES = LT_UNIT_CYC  // Cycles per timer step
) (
  input  wire logic           i_mclk,         // Core clock
  input  wire logic           i_rst,          // Async reset, high
  input  wire logic           i_std_pin,      // Standard strap, async
  input  wire logic           i_sync_lost,    // Receiver lost sync
  input  wire logic           i_partner_cfg,  // Partner is negotiating
  input  wire link_timer_type i_link_timer,   // Per-standard timer settings
  input  wire logic [4:0]     i_phy_addr,     // Management address
  input  wire logic           i_mdc,          // Management clock pin
  input  wire logic           i_mdio_in,      // Management data in
  output logic                o_mdio_out,     // Management data out
  output logic                o_mdio_oe,      // Management drive enable
  output logic                o_neg_done_irq, // Completion interrupt
  output std_type             o_standard,     // Register-side standard
  output std_type             o_neg_standard, // Standard of current sequence
  output logic                o_an_complete,  // Sequence finished
  output logic [15:0]         o_adv           // Advertised abilities
);

  initial begin
    if (LT_UNIT_CYCLES < 1 || LT_UNIT_CYCLES > 16384) begin
      $error("LT_UNIT_CYCLES out of range");
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] mdc_s_q;
  logic [1:0] mdio_s_q;
  logic [1:0] pin_s_q;

  // Only stage 1 and later feed logic; stage 0 may be metastable
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mdc_s_q  <= 3'h0;
      mdio_s_q <= 2'h0;
      pin_s_q  <= 2'h0;
    end else begin
      mdc_s_q  <= {mdc_s_q[1:0], i_mdc};
      mdio_s_q <= {mdio_s_q[0], i_mdio_in};
      pin_s_q  <= {pin_s_q[0], i_std_pin};
    end
  end

  wire mdc_rise = mdc_s_q[1] & ~mdc_s_q[2];
  wire mdio_bit = mdio_s_q[1];

  // ----------------------------------------------------------------
  // Management frame engine
  // ----------------------------------------------------------------
  mdio_state_type mst_q;
  logic [5:0]     pre_cnt_q;
  logic [4:0]     bit_cnt_q;
  logic [15:0]    shift_q;
  logic [15:0]    rd_data_q;
  logic [4:0]     regad_q;
  logic           wr_stb_q;
  logic [4:0]     wr_addr_q;
  logic [15:0]    wr_data_q;
  logic           mdio_out_q;
  logic           mdio_oe_q;

  // Register read view; depends on the standard in force
  logic [15:0] ctrl_q;
  logic [15:0] adv_q;
  logic        irq_en_q;
  logic        irq_stat_q;
  std_type     std_q;
  neg_state_type nst_q;

  function automatic logic [15:0] reg_read(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0000;
    unique case (a)
      REG_CTRL: v = ctrl_q;
      REG_STAT: begin
        v[STAT_ABIL_BIT] = 1'b1;
        v[STAT_DONE_BIT] = (nst_q == N_DONE);
      end
      REG_ADV:  v = (std_q == STD_SGMII) ? ADV_SGMII : adv_q;
      REG_IRQ:  begin
        v[IRQ_EN_BIT]   = irq_en_q;
        v[IRQ_STAT_BIT] = irq_stat_q;
      end
      REG_STD:  v[0] = std_q;
      default:  v = 16'h0000;
    endcase
    return v;
  endfunction

  wire [15:0] shift_in  = {shift_q[14:0], mdio_bit};
  wire        hdr_last  = (bit_cnt_q == HDR_LEN - 5'h01);
  wire        hdr_ok    = shift_in[12] && (shift_in[9:5] == i_phy_addr);
  wire [4:0]  rd_idx    = 5'h10 - bit_cnt_q;

  // Samples on rising management clock, drives just after it
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mst_q      <= M_PRE;
      pre_cnt_q  <= 6'h00;
      bit_cnt_q  <= 5'h00;
      shift_q    <= 16'h0000;
      rd_data_q  <= 16'h0000;
      regad_q    <= 5'h00;
      wr_stb_q   <= 1'b0;
      wr_addr_q  <= 5'h00;
      wr_data_q  <= 16'h0000;
      mdio_out_q <= 1'b0;
      mdio_oe_q  <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (mdc_rise) begin
        unique case (mst_q)
          M_PRE: begin
            bit_cnt_q <= 5'h00;
            if (mdio_bit) begin
              pre_cnt_q <= (pre_cnt_q == PRE_LEN) ? PRE_LEN : pre_cnt_q + 6'h01;
            end else begin
              pre_cnt_q <= 6'h00;
              if (pre_cnt_q == PRE_LEN) begin
                mst_q <= M_HDR;
              end
            end
          end
          M_HDR: begin
            shift_q   <= shift_in;
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (hdr_last) begin
              bit_cnt_q <= 5'h00;
              regad_q   <= shift_in[4:0];
              rd_data_q <= reg_read(shift_in[4:0]);
              if (hdr_ok && shift_in[11:10] == OP_RD) begin
                mst_q <= M_RD;
              end else if (hdr_ok && shift_in[11:10] == OP_WR) begin
                mst_q <= M_WR;
              end else begin
                mst_q <= M_PRE;
              end
            end
          end
          M_RD: begin
            bit_cnt_q  <= bit_cnt_q + 5'h01;
            // Turnaround, sixteen data bits, then release on the next rise
            mdio_oe_q  <= (bit_cnt_q != RD_LEN);
            mdio_out_q <= (bit_cnt_q == 5'h00) ? 1'b0 : rd_data_q[rd_idx[3:0]];
            if (bit_cnt_q == RD_LEN) begin
              mdio_out_q <= 1'b0;
              mst_q      <= M_PRE;
            end
          end
          M_WR: begin
            shift_q   <= shift_in;
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == WR_LEN - 5'h01) begin
              wr_stb_q  <= 1'b1;
              wr_addr_q <= regad_q;
              wr_data_q <= shift_in;
              mst_q     <= M_PRE;
            end
          end
          default: mst_q <= M_PRE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  wire wr_ctrl = wr_stb_q && (wr_addr_q == REG_CTRL);
  wire wr_adv  = wr_stb_q && (wr_addr_q == REG_ADV) && (std_q == STD_BASEX);
  wire wr_irq  = wr_stb_q && (wr_addr_q == REG_IRQ);
  wire wr_std  = wr_stb_q && (wr_addr_q == REG_STD);
  wire restart = wr_ctrl && wr_data_q[CTRL_RESTART_BIT];
  wire an_en   = ctrl_q[CTRL_ANEN_BIT];

  logic [1:0] strap_cnt_q;
  logic       boot_q;
  // strap is looked at only after a reset release
  wire strap_load = (strap_cnt_q == STRAP_DLY - 2'h1);

  // Strap capture waits for the synchroniser to fill after release
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      strap_cnt_q <= 2'h0;
      boot_q      <= 1'b0;
    end else begin
      strap_cnt_q <= (strap_cnt_q == STRAP_DLY) ? STRAP_DLY : strap_cnt_q + 2'h1;
      boot_q      <= strap_load;
    end
  end

  // strap or register write picks the standard
  wire std_type std_d = strap_load ? std_type'(pin_s_q[1]) :
                        wr_std     ? std_type'(wr_data_q[0]) : std_q;

  // Restart is self-clearing and never stored
  wire [15:0] ctrl_d = wr_ctrl ? (wr_data_q & ~(16'h0001 << CTRL_RESTART_BIT)) : ctrl_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= CTRL_RST;
      adv_q  <= ADV_RST;
      std_q  <= STD_BASEX;
    end else begin
      ctrl_q <= ctrl_d;
      adv_q  <= wr_adv ? wr_data_q : adv_q;
      std_q  <= std_d;
    end
  end

  // ----------------------------------------------------------------
  // Negotiation sequencer
  // ----------------------------------------------------------------
  logic       sl_q;
  logic       pc_q;
  logic [13:0] unit_cnt_q;
  logic [8:0] tick_cnt_q;
  logic [1:0] per_cnt_q;
  logic [8:0] lt_q;
  std_type    neg_std_q;

  // start triggers; partner start matters only outside a sequence
  wire start = an_en && (boot_q || restart || (i_sync_lost && !sl_q) ||
               (i_partner_cfg && !pc_q && nst_q != N_RUN));
  wire [8:0] lt_sel = (std_q == STD_SGMII) ? i_link_timer.sgmii : i_link_timer.basex;
  // A zero setting would only expire after 512 steps, so it counts as one step
  wire [8:0] lt_eff = (lt_q == 9'h000) ? 9'h001 : lt_q;
  wire unit_end = (unit_cnt_q == 14'(LT_UNIT_CYCLES - 1));
  wire per_end  = unit_end && (tick_cnt_q == lt_eff - 9'h001);
  wire finish   = (nst_q == N_RUN) && per_end && (per_cnt_q == 2'(LT_PERIODS - 1)) && !start;

  neg_state_type nst_d;
  always_comb begin
    nst_d = nst_q;
    unique case (nst_q)
      N_IDLE:  nst_d = start ? N_RUN : N_IDLE;
      N_RUN:   nst_d = start ? N_RUN : !an_en ? N_IDLE : finish ? N_DONE : N_RUN;
      N_DONE:  nst_d = start ? N_RUN : an_en ? N_DONE : N_IDLE;
      default: nst_d = N_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      nst_q      <= N_IDLE;
      sl_q       <= 1'b0;
      pc_q       <= 1'b0;
      unit_cnt_q <= 14'h0000;
      tick_cnt_q <= 9'h000;
      per_cnt_q  <= 2'h0;
      lt_q       <= 9'h000;
      neg_std_q  <= STD_BASEX;
    end else begin
      nst_q <= nst_d;
      sl_q  <= i_sync_lost;
      pc_q  <= i_partner_cfg;
      if (start) begin
        // standard and setting frozen for the sequence
        lt_q       <= lt_sel;
        neg_std_q  <= std_q;
        unit_cnt_q <= 14'h0000;
        tick_cnt_q <= 9'h000;
        per_cnt_q  <= 2'h0;
      end else if (nst_q == N_RUN) begin
        unit_cnt_q <= unit_end ? 14'h0000 : unit_cnt_q + 14'h0001;
        if (unit_end) begin
          tick_cnt_q <= per_end ? 9'h000 : tick_cnt_q + 9'h001;
        end
        if (per_end) begin
          per_cnt_q <= per_cnt_q + 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Completion interrupt
  // ----------------------------------------------------------------
  // a zero written to the status bit clears; completion wins a tie
  wire irq_clr    = wr_irq && !wr_data_q[IRQ_STAT_BIT];
  wire irq_en_d   = wr_irq ? wr_data_q[IRQ_EN_BIT] : irq_en_q;
  wire irq_stat_d = (finish && irq_en_q) || (irq_stat_q && !irq_clr);

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      irq_en_q       <= 1'b0;
      irq_stat_q     <= 1'b0;
      o_neg_done_irq <= 1'b0;
    end else begin
      irq_en_q       <= irq_en_d;
      irq_stat_q     <= irq_stat_d;
      o_neg_done_irq <= irq_stat_d && irq_en_d;
    end
  end

  assign o_mdio_out     = mdio_out_q;
  assign o_mdio_oe      = mdio_oe_q;
  assign o_standard     = std_q;
  assign o_neg_standard = neg_std_q;
  assign o_an_complete  = nst_q[2];
  assign o_adv          = adv_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] run_len_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      run_len_q <= 32'h0;
    end else begin
      run_len_q <= start ? 32'h0 : (nst_q == N_RUN) ? run_len_q + 32'h1 : run_len_q;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  property p_three_periods;
    $rose(nst_q == N_DONE) |->
      run_len_q == 32'(LT_PERIODS) * 32'(lt_eff) * 32'(LT_UNIT_CYCLES);
  endproperty
  a_three_periods: assert property (p_three_periods) else $error("sequence length wrong");

  property p_irq_off;
    !irq_en_q |-> !o_neg_done_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt high while disabled");

  property p_irq_on;
    finish && irq_en_q && !wr_irq |=> o_neg_done_irq && irq_stat_q;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt missing after completion");

  property p_irq_hold;
    o_neg_done_irq && !wr_irq |=> o_neg_done_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without clear");

  property p_strap;
    strap_load |=> std_q == $past(pin_s_q[1]) ##1 nst_q == (an_en ? N_RUN : N_IDLE);
  endproperty
  a_strap: assert property (p_strap) else $error("strap not applied");

  property p_keep_std;
    nst_q == N_RUN && !start |=> $stable(neg_std_q) && $stable(lt_q);
  endproperty
  a_keep_std: assert property (p_keep_std) else $error("sequence standard changed");

  property p_no_auto;
    wr_std && !start && nst_q == N_IDLE |=> nst_q == N_IDLE;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("standard write started sequence");

  property p_restart;
    restart && an_en |=> nst_q == N_RUN && unit_cnt_q == 14'h0000 && per_cnt_q == 2'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart ignored");

  property p_sample;
    start |=> lt_q == $past(lt_sel) && neg_std_q == $past(std_q);
  endproperty
  a_sample: assert property (p_sample) else $error("timer setting not sampled");

endmodule

// File: mdio_host_model.sv
module mdio_host_model
  import autoneg_pkg::*;
#(
  parameter int         HALF = 8,     // Core cycles per management half period
  parameter logic [4:0] PHY  = 5'h05  // Address put in every frame
) (
  input  wire logic i_mclk,      // Core clock
  input  wire logic i_mdio_line, // Resolved data line
  output logic      o_mdc,       // Management clock, still between frames
  output logic      o_mdio_drv,  // Host data value
  output logic      o_mdio_oe    // Host drives the line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_mdc      = 1'b0;
    o_mdio_drv = 1'b1;
    o_mdio_oe  = 1'b0;
  end

  // One bit: data changes while the clock is low, sampled at the rise
  task automatic bit_cycle(input logic drv, input logic val, output logic smp);
    @(posedge i_mclk);
    o_mdc      <= 1'b0;
    o_mdio_oe  <= drv;
    o_mdio_drv <= drv ? val : ~val;
    repeat (HALF) @(posedge i_mclk);
    o_mdc <= 1'b1;
    smp = i_mdio_line;
    repeat (HALF - 1) @(posedge i_mclk);
  endtask

  // Whole frame, always with a fresh preamble
  task automatic frame(input logic [1:0] op, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, op, PHY, ra};
    rd  = 16'h0000;
    for (int i = 0; i < 32; i++) bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cycle(1'b1, hdr[i], s);
    if (op == OP_RD) begin
      // Device answers one rise late, so data shows from the third rise
      for (int i = 0; i < 18; i++) begin
        bit_cycle(1'b0, 1'b1, s);
        if (i >= 2) rd = {rd[14:0], s};
      end
    end else begin
      bit_cycle(1'b1, 1'b1, s);
      bit_cycle(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) bit_cycle(1'b1, wd[i], s);
    end
    @(posedge i_mclk);
    o_mdc     <= 1'b0;
    o_mdio_oe <= 1'b0;
    repeat (4 * HALF) @(posedge i_mclk);
  endtask

  task automatic mgmt_write(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    frame(OP_WR, ra, wd, d);
  endtask

  task automatic mgmt_read(input logic [4:0] ra, output logic [15:0] rd);
    frame(OP_RD, ra, 16'h0000, rd);
  endtask
endmodule

// File: tb_autoneg_standard_switch_ctrl.sv
module tb_autoneg_standard_switch_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import autoneg_pkg::*;

  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  localparam int         UNIT  = 4;
  localparam logic [4:0] PHY_A = 5'h05;
  localparam int         BOOT  = LT_PERIODS * 3 * UNIT;   // basex setting 3
  localparam int         SGM   = LT_PERIODS * 100 * UNIT; // sgmii setting 100

  logic           i_mclk        = 1'b0;
  logic           i_rst         = 1'b1;
  logic           i_std_pin     = 1'b0;
  logic           i_sync_lost   = 1'b0;
  logic           i_partner_cfg = 1'b0;
  link_timer_type i_link_timer  = '{basex: 9'h003, sgmii: 9'h064};
  logic           mdc, host_d, host_oe, mdio_line;
  logic           o_mdio_out, o_mdio_oe, o_neg_done_irq, o_an_complete;
  std_type        o_standard, o_neg_standard;
  logic [15:0]    o_adv, rd;
  int             err_count   = 0;
  int             checks_done = 0;
  int             cyc         = 0;
  int             n, t0;

  always #2 i_mclk = ~i_mclk;

  // Pull-up wins when nobody drives the line
  assign mdio_line = o_mdio_oe ? o_mdio_out : (host_oe ? host_d : 1'b1);

  autoneg_standard_switch_ctrl #(.LT_UNIT_CYCLES(UNIT)) dut_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_std_pin(i_std_pin),
    .i_sync_lost(i_sync_lost), .i_partner_cfg(i_partner_cfg),
    .i_link_timer(i_link_timer), .i_phy_addr(PHY_A), .i_mdc(mdc),
    .i_mdio_in(mdio_line), .o_mdio_out(o_mdio_out), .o_mdio_oe(o_mdio_oe),
    .o_neg_done_irq(o_neg_done_irq), .o_standard(o_standard),
    .o_neg_standard(o_neg_standard), .o_an_complete(o_an_complete), .o_adv(o_adv));

  mdio_host_model #(.HALF(8), .PHY(PHY_A)) host_u (
    .i_mclk(i_mclk), .i_mdio_line(mdio_line), .o_mdc(mdc),
    .o_mdio_drv(host_d), .o_mdio_oe(host_oe));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Sample where outputs have settled, bounded wait
  task automatic wait_an(input logic v, input int lim, output int k);
    k = 0;
    while (o_an_complete !== v && k < lim) begin
      @(negedge i_mclk);
      k++;
    end
  endtask

  task automatic do_reset();
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    wait_an(1'b1, 100, n);
    check("boot_min", n >= BOOT, 1'b1);
    check("boot_max", n <= BOOT + 10, 1'b1);
    check("boot_done", o_an_complete, 1'b1);
    check("irq_off", o_neg_done_irq, 1'b0);
    check("std_strap0", o_standard, STD_BASEX);
    check("adv_reset", o_adv, ADV_RST);
    host_u.mgmt_read(REG_STD, rd);
    check("std_readback", rd, 16'h0000);
    host_u.mgmt_read(5'h02, rd);
    check("unmapped", rd, 16'h0000);
    host_u.mgmt_read(REG_STAT, rd);
    check("status", rd, 16'h0028);
    // Enable then restart; only a fresh completion may raise the output
    host_u.mgmt_write(REG_IRQ, 16'h0001);
    host_u.mgmt_write(REG_CTRL, 16'h1200);
    wait_an(1'b1, 100, n);
    repeat (2) @(negedge i_mclk);
    check("irq_set", o_neg_done_irq, 1'b1);
    host_u.mgmt_read(REG_IRQ, rd);
    check("irq_reg", rd, 16'h0003);
    host_u.mgmt_write(REG_IRQ, 16'h0003);
    check("irq_hold", o_neg_done_irq, 1'b1);
    // host writes zero to the status bit
    host_u.mgmt_write(REG_IRQ, 16'h0001);
    check("irq_clear", o_neg_done_irq, 1'b0);
    host_u.mgmt_read(REG_IRQ, rd);
    check("irq_reg_clr", rd, 16'h0001);
    // Switch to the copper standard while idle in done
    host_u.mgmt_write(REG_STD, 16'h0001);
    check("std_sgmii", o_standard, STD_SGMII);
    check("no_restart", o_an_complete, 1'b1);
    host_u.mgmt_read(REG_ADV, rd);
    check("adv_sgmii", rd, ADV_SGMII);
    // Restart, then switch back while the long sequence runs
    host_u.mgmt_write(REG_CTRL, 16'h1200);
    t0 = cyc;
    host_u.mgmt_write(REG_STD, 16'h0000);
    check("std_basex", o_standard, STD_BASEX);
    check("neg_kept", o_neg_standard, STD_SGMII);
    check("still_run", o_an_complete, 1'b0);
    wait_an(1'b1, 400, n);
    check("sgmii_len", (cyc - t0 > SGM - 50) && (cyc - t0 < SGM + 10), 1'b1);
    // host rewrites advertisement after going back
    host_u.mgmt_write(REG_ADV, 16'h01A0);
    check("adv_new", o_adv, 16'h01A0);
    // Sync loss and partner start each run a fresh sequence
    for (int k = 0; k < 2; k++) begin
      @(posedge i_mclk);
      if (k == 0) i_sync_lost <= 1'b1;
      else i_partner_cfg <= 1'b1;
      @(posedge i_mclk);
      i_sync_lost   <= 1'b0;
      i_partner_cfg <= 1'b0;
      wait_an(1'b0, 8, n);
      check("seq_start", o_an_complete, 1'b0);
      wait_an(1'b1, BOOT + 10, n);
      check("seq_len", n >= BOOT - 4, 1'b1);
    end
    // level first, nothing changes until a reset
    @(posedge i_mclk);
    i_std_pin <= 1'b1;
    repeat (20) @(negedge i_mclk);
    check("strap_wait", o_standard, STD_BASEX);
    do_reset();
    repeat (10) @(negedge i_mclk);
    check("std_strap1", o_standard, STD_SGMII);
    check("irq_rst", o_neg_done_irq, 1'b0);
    host_u.mgmt_read(REG_STD, rd);
    check("std_readback1", rd, 16'h0001);
    tally_and_finish();
  end
endmodule
